// [core/rsc_pkg.sv]
package rsc_pkg;
  localparam int unsigned CLK_PERIOD_NS   = 40;
  localparam int unsigned SRESET_DELAY_NS = 10000;
  localparam int unsigned LVQ_TIME_NS     = 120000;
  localparam logic [15:0] SRESET_CYC =
    16'((SRESET_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] LVQ_CYC =
    16'((LVQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0]  RST_HOLD_CYC    = 4'h8;

  localparam logic [7:0]  ADDR_LV_SELECT  = 8'h00;
  localparam logic [7:0]  ADDR_RST_FLAGS  = 8'h04;
  localparam logic [7:0]  ADDR_WDT_CTRL   = 8'h08;
  localparam logic [7:0]  ADDR_STATUS     = 8'h0c;

  localparam logic [7:0]  LVS_ENABLE_17V  = 8'h5a;
  localparam logic [7:0]  LVS_DISABLE     = 8'ha5;
  localparam logic [7:0]  LVS_POR         = 8'h5a;
  localparam logic [4:0]  WEC_DISABLE     = 5'h15;
  localparam logic [4:0]  WEC_ENABLE      = 5'h0a;
  localparam logic [7:0]  WDOG_CTRL_POR   = 8'h57;
  localparam logic [2:0]  FLAGS_POR       = 3'h0;
  localparam logic [1:0]  STATUS_POR      = 2'h0;

  localparam int unsigned FLG_LV          = 2;
  localparam int unsigned FLG_LSC         = 1;
  localparam int unsigned FLG_WSC         = 0;
  localparam int unsigned STS_PWR_DOWN    = 1;
  localparam int unsigned STS_EXPIRY      = 0;

  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  typedef enum logic [1:0] {
    ST_RUN  = 2'b01,
    ST_HOLD = 2'b10
  } rsc_state_t;
endpackage

// [core/rsc_tmr_if.sv]
`timescale 1ns/1ns
`default_nettype none
interface rsc_tmr_if;
  logic run;
  logic done;
  modport ctl (output run, input done);
  modport tmr (input run, output done);
endinterface
`default_nettype wire

// [core/rsc_delay_timer.sv]
`timescale 1ns/1ns
`default_nettype none
module rsc_delay_timer
  import rsc_pkg::*;
#(
  parameter logic [15:0] CYCLES = 16'h0001
)
(
  input  wire logic aclk,
  input  wire logic aresetn,
  rsc_tmr_if.tmr    tif
);
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;

  // Dropping run restarts the count, so only an unbroken episode expires
  assign cnt_nxt = !tif.run ? 16'h0000 : (cnt_r == CYCLES) ? cnt_r : cnt_r + 16'h0001;
  assign tif.done = tif.run && (cnt_r == CYCLES);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cnt_r <= 16'h0000;
    else
      cnt_r <= cnt_nxt;
  end
endmodule // rsc_delay_timer
`default_nettype wire

// [core/rsc_reset_ctrl.sv]
// Overview of operation
// R01 - Select code 0x5a arms the 1.7V low-voltage reset; 0xa5 disables it.
// R02 - Any other select code gives a full reset after the soft reset delay.
// R03 - A reset from a bad select code reloads the select register with 0x5a.
// R04 - Low supply must persist past the qualify time before a reset is issued.
// R05 - A genuine low-voltage reset leaves the select register unchanged.
// R06 - Low-voltage cause flag, bit 2, set by hardware, cleared only by writing 0.
// R07 - Select-code error flag, bit 1, set on such reset, cleared only by writing 0.
// R08 - Flag register bits 7 to 3 always read zero.
// R09 - Watchdog expiry in normal run resets the device and sets the expiry flag.
// R10 - Expiry in sleep or idle clears only PC and SP, sets both status flags.
// R11 - Expiry in sleep or idle keeps every other state unchanged.
// R12 - A low-voltage reset leaves expiry and power-down flags unchanged.
// R13 - Power-on reset forces PC to zero and disables all interrupts.
// R14 - Power-on reset clears watchdog and time base; watchdog runs after release.
// R15 - Power-on reset sets all port pins to input and SP to stack top.
// R16 - Watchdog-code error flag, bit 0, set on such reset, cleared only by software.
// R17 - Watchdog code 10101 disables, 01010 enables, others reset after the delay.
// R18 - Low-voltage detection is suppressed in idle or sleep.
// R19 - All requests merge into one clocked reset output with fixed cause priority.
// R20 - Soft reset delay and qualify time are configurable cycle counts.
//
// The AXI4-Lite interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module rsc_reset_ctrl
  import rsc_pkg::*;
#(
  parameter logic [15:0] SRESET_CYCLES = SRESET_CYC,
  parameter logic [15:0] LVQ_CYCLES    = LVQ_CYC
)
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        low_supply,
  input  wire logic        sleep_mode,
  input  wire logic        idle_mode,
  input  wire logic        wdt_expire,
  output logic             core_rst_n,
  output logic             por_load,
  output logic             pc_sp_clear,
  output logic             wdt_enable,
  output logic             lvr_armed
);
  rsc_state_t  state_r;
  rsc_state_t  state_nxt;
  logic [3:0]  hold_cnt_r;
  logic        lows_s1_r;
  logic        lows_s2_r;
  logic [7:0]  lv_select_r;
  logic [7:0]  wdt_ctrl_r;
  logic [2:0]  flags_r;
  logic [1:0]  status_r;
  logic        core_rst_n_r;
  logic        por_load_r;
  logic        pc_sp_clear_r;
  logic        wdt_enable_r;
  logic        lvr_armed_r;
  logic        aw_hold_r;
  logic [7:0]  aw_addr_r;
  logic        w_hold_r;
  logic [7:0]  w_data_r;
  logic        w_strb0_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;

  rsc_tmr_if lvq_if ();
  rsc_tmr_if lsc_if ();
  rsc_tmr_if wsc_if ();

  // Supply indication is asynchronous to aclk
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      lows_s1_r <= 1'b0;
      lows_s2_r <= 1'b0;
    end
    else
    begin
      lows_s1_r <= low_supply;
      lows_s2_r <= lows_s1_r;
    end
  end

  wire       running   = (state_r == ST_RUN);
  wire       halted    = sleep_mode | idle_mode;
  wire       lv_on     = (lv_select_r == LVS_ENABLE_17V); // R01
  wire       lv_bad    = !lv_on && (lv_select_r != LVS_DISABLE); // R01
  wire [4:0] wdt_code  = wdt_ctrl_r[7:3];
  wire       wd_bad    = (wdt_code != WEC_ENABLE) && (wdt_code != WEC_DISABLE); // R17

  assign lvq_if.run = running && lv_on && lows_s2_r && !halted; // R04 R18
  assign lsc_if.run = running && lv_bad; // R02
  assign wsc_if.run = running && wd_bad; // R17

  rsc_delay_timer #(.CYCLES(LVQ_CYCLES)) u_lvq_tmr // R20
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tif     (lvq_if.tmr)
  );

  rsc_delay_timer #(.CYCLES(SRESET_CYCLES)) u_lsc_tmr // R20
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tif     (lsc_if.tmr)
  );

  rsc_delay_timer #(.CYCLES(SRESET_CYCLES)) u_wsc_tmr
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tif     (wsc_if.tmr)
  );

  // Cause priority: low voltage, select code, watchdog code, expiry
  wire go_lvr    = lvq_if.done; // R19
  wire go_lsc    = lsc_if.done && !go_lvr; // R19
  wire go_wsc    = wsc_if.done && !go_lvr && !lsc_if.done; // R19
  wire wto_req   = running && wdt_expire;
  wire go_wto    = wto_req && !halted && !lvq_if.done && !lsc_if.done && !wsc_if.done; // R09
  wire sleep_wto = wto_req && halted && !lsc_if.done && !wsc_if.done; // R10 R11
  wire go        = go_lvr || go_lsc || go_wsc || go_wto; // R19

  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      ST_RUN:  if (go) state_nxt = ST_HOLD;
      ST_HOLD: if (hold_cnt_r == RST_HOLD_CYC - 4'h1) state_nxt = ST_RUN;
    endcase
  end

  // Register bus write path
  wire wr_do     = aw_hold_r && w_hold_r && !bvalid_r;
  wire wr_lvs    = wr_do && w_strb0_r && (aw_addr_r == ADDR_LV_SELECT);
  wire wr_flg    = wr_do && w_strb0_r && (aw_addr_r == ADDR_RST_FLAGS);
  wire wr_wdc    = wr_do && w_strb0_r && (aw_addr_r == ADDR_WDT_CTRL);
  wire wr_sts    = wr_do && w_strb0_r && (aw_addr_r == ADDR_STATUS);
  wire wr_hit    = (aw_addr_r == ADDR_LV_SELECT) || (aw_addr_r == ADDR_RST_FLAGS) ||
                   (aw_addr_r == ADDR_WDT_CTRL) || (aw_addr_r == ADDR_STATUS);

  // Hardware set wins over a software clear in the same cycle
  wire [2:0] flg_clr  = wr_flg ? ~w_data_r[2:0] : 3'h0;
  wire [2:0] flg_set  = {go_lvr, go_lsc, go_wsc}; // R06 R07 R16
  wire [2:0] flags_nxt = (flags_r & ~flg_clr) | flg_set; // R06 R07 R16
  wire [1:0] sts_clr  = wr_sts ? ~w_data_r[1:0] : 2'h0;
  wire [1:0] sts_set  = {sleep_wto, sleep_wto || go_wto}; // R09 R10 R12
  wire [1:0] status_nxt = (status_r & ~sts_clr) | sts_set; // R09 R10 R12

  // A genuine low-voltage reset must not disturb the select code
  wire [7:0] lv_select_nxt = (go && !go_lvr) ? LVS_POR : // R03 R05
                             wr_lvs ? w_data_r : lv_select_r;
  wire [7:0] wdt_ctrl_nxt  = go ? WDOG_CTRL_POR : wr_wdc ? w_data_r : wdt_ctrl_r;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_r       <= ST_RUN;
      hold_cnt_r    <= 4'h0;
      lv_select_r   <= LVS_POR;
      wdt_ctrl_r    <= WDOG_CTRL_POR;
      flags_r       <= FLAGS_POR;
      status_r      <= STATUS_POR;
      core_rst_n_r  <= 1'b0;
      por_load_r    <= 1'b1;
      pc_sp_clear_r <= 1'b0;
      wdt_enable_r  <= 1'b0;
      lvr_armed_r   <= 1'b0;
    end
    else
    begin
      state_r       <= state_nxt;
      hold_cnt_r    <= running ? 4'h0 : hold_cnt_r + 4'h1;
      lv_select_r   <= lv_select_nxt;
      wdt_ctrl_r    <= wdt_ctrl_nxt;
      flags_r       <= flags_nxt;
      status_r      <= status_nxt;
      core_rst_n_r  <= (state_nxt == ST_RUN); // R19
      por_load_r    <= 1'b0; // R13 R14 R15
      pc_sp_clear_r <= sleep_wto; // R10
      wdt_enable_r  <= (wdt_code == WEC_ENABLE) && (state_nxt == ST_RUN); // R14 R17
      lvr_armed_r   <= lv_on && !halted; // R18
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_hold_r  <= 1'b0;
      w_data_r  <= 8'h00;
      w_strb0_r <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && !aw_hold_r)
      begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= {s_axi_awaddr[7:2], 2'b00};
      end
      else if (wr_do)
        aw_hold_r <= 1'b0;
      if (s_axi_wvalid && !w_hold_r)
      begin
        w_hold_r  <= 1'b1;
        w_data_r  <= s_axi_wdata[7:0];
        w_strb0_r <= s_axi_wstrb[0];
      end
      else if (wr_do)
        w_hold_r <= 1'b0;
      if (wr_do)
      begin
        bvalid_r <= 1'b1;
        bresp_r  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
        bvalid_r <= 1'b0;
    end
  end

  // Register bus read path
  wire [7:0] rd_addr = {s_axi_araddr[7:2], 2'b00};
  wire       rd_take = s_axi_arvalid && !rvalid_r;
  wire       rd_hit  = (rd_addr == ADDR_LV_SELECT) || (rd_addr == ADDR_RST_FLAGS) ||
                       (rd_addr == ADDR_WDT_CTRL) || (rd_addr == ADDR_STATUS);
  wire [7:0] rd_byte = (rd_addr == ADDR_LV_SELECT) ? lv_select_r :
                       (rd_addr == ADDR_RST_FLAGS) ? {5'h00, flags_r} : // R08
                       (rd_addr == ADDR_WDT_CTRL)  ? wdt_ctrl_r :
                       (rd_addr == ADDR_STATUS)    ? {6'h00, status_r} : 8'h00;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= RESP_OKAY;
    end
    else if (rd_take)
    begin
      rvalid_r <= 1'b1;
      rdata_r  <= {24'h00_0000, rd_byte};
      rresp_r  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready)
      rvalid_r <= 1'b0;
  end

  assign s_axi_awready = !aw_hold_r;
  assign s_axi_wready  = !w_hold_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
  assign core_rst_n    = core_rst_n_r;
  assign por_load      = por_load_r;
  assign pc_sp_clear   = pc_sp_clear_r;
  assign wdt_enable    = wdt_enable_r;
  assign lvr_armed     = lvr_armed_r;

  logic rd_flg_r;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      rd_flg_r <= 1'b0;
    else if (rd_take)
      rd_flg_r <= (rd_addr == ADDR_RST_FLAGS);
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_lvs_bad_reload: assert property (go_lsc |=> lv_select_r == LVS_POR) // R03
    else $error("select code not reloaded after code error reset");
  a_lvs_keep_lvr: assert property (go_lvr |=> lv_select_r == $past(lv_select_r)) // R05
    else $error("select code changed by low-voltage reset");
  a_lvf_sticky: assert property (flags_r[FLG_LV] && !flg_clr[FLG_LV] |=> flags_r[FLG_LV]) // R06
    else $error("low-voltage flag lost without software clear");
  a_lsc_flag_set: assert property (lsc_if.done && !go_lvr |=> flags_r[FLG_LSC] && !core_rst_n_r) // R02 R07
    else $error("select code error did not reset and flag");
  a_wsc_flag_set: assert property (go_wsc |=> flags_r[FLG_WSC] && wdt_ctrl_r == WDOG_CTRL_POR) // R16 R17
    else $error("watchdog code error not handled");
  a_rsvd_zero: assert property (rvalid_r && rd_flg_r |-> rdata_r[31:3] == 29'h0) // R08
    else $error("reserved flag bits not zero");
  a_wto_normal: assert property (go_wto |=> !core_rst_n_r && status_r[STS_EXPIRY]) // R09
    else $error("normal expiry did not reset and set expiry flag");
  a_wto_sleep: assert property (sleep_wto |=> core_rst_n_r && pc_sp_clear_r && // R10 R11
                                status_r == 2'h3 && $stable(lv_select_r))
    else $error("sleep expiry handled wrongly");
  a_lvr_keeps_sts: assert property (go_lvr |=> status_r == $past(status_r)) // R12
    else $error("low-voltage reset touched status flags");
  a_lvq_short: assert property (!lvq_if.run |=> !go_lvr) // R04 R18
    else $error("low-voltage reset without qualified episode");
  a_por_outputs: assert property ($rose(aresetn) |-> // R13 R14 R15
                                  por_load_r && !core_rst_n_r && !wdt_enable_r ##1
                                  !por_load_r && core_rst_n_r)
    else $error("power-on defaults not presented");
  // Only a generated reset counts; a power-on pulse may be as short as one edge
  a_hold_len: assert property ($fell(core_rst_n_r) && $past(aresetn) |-> // R19
                               !core_rst_n_r [*8] ##1 core_rst_n_r)
    else $error("generated reset length wrong");

  c_lvr_reset: cover property (go_lvr ##1 !core_rst_n_r);
  c_lsc_reset: cover property (go_lsc);
  c_sleep_wto: cover property (sleep_wto ##1 pc_sp_clear_r);
  c_flag_clear: cover property (flags_r[FLG_LV] ##1 !flags_r[FLG_LV]);
endmodule // rsc_reset_ctrl
`default_nettype wire

// [verification/rsc_reset_ctrl_test.sv]
`timescale 1ns/1ns
`default_nettype none
module rsc_reset_ctrl_test
  import rsc_pkg::*;
;
  // Short counts keep the run brief; every wait below is bounded from these
  localparam logic [15:0] SR_CYC = 16'h0004;
  localparam logic [15:0] LQ_CYC = 16'h0008;

  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, low_supply, sleep_mode, idle_mode;
  logic        wdt_expire, core_rst_n, por_load, pc_sp_clear, wdt_enable, lvr_armed;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  int          n_fail = 0;
  int          checks = 0;

  rsc_reset_ctrl #(.SRESET_CYCLES(SR_CYC), .LVQ_CYCLES(LQ_CYC)) u_dut
  (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .low_supply(low_supply), .sleep_mode(sleep_mode), .idle_mode(idle_mode),
    .wdt_expire(wdt_expire), .core_rst_n(core_rst_n), .por_load(por_load),
    .pc_sp_clear(pc_sp_clear), .wdt_enable(wdt_enable), .lvr_armed(lvr_armed)
  );

  initial
  begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  task automatic summarize();
    $display("checks %0d, mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic give_up(input string what);
    n_fail++;
    $display("[FAIL] %s expected an answer seen a timeout", what);
    summarize();
  endtask

  // Ready channels are held high throughout, so no release can collide with a new request
  task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (int i = 0; i < 40; i++)
    begin
      @(posedge aclk);
      if (aw_ok && w_ok && bvalid === 1'b1)
      begin
        r = bresp;
        return;
      end
      if (!aw_ok && awready === 1'b1)
      begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1)
      begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    give_up("write response");
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic taken;
    taken = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    for (int i = 0; i < 40; i++)
    begin
      @(posedge aclk);
      if (taken && rvalid === 1'b1)
      begin
        d = rdata;
        r = rresp;
        return;
      end
      if (!taken && arready === 1'b1)
      begin
        taken = 1'b1;
        arvalid <= 1'b0;
      end
    end
    give_up("read data");
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
    chk("write response", {30'h0, RESP_OKAY}, {30'h0, r});
  endtask

  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(a, d, r);
    chk(what, exp, d);
    chk("read response", {30'h0, RESP_OKAY}, {30'h0, r});
  endtask

  task automatic expect_rst(input string what, input int bound);
    int lo;
    lo = 0;
    for (int i = 0; i < bound && core_rst_n !== 1'b0; i++)
      @(posedge aclk);
    if (core_rst_n !== 1'b0)
      give_up(what);
    while (core_rst_n === 1'b0 && lo < 40)
    begin
      lo++;
      @(posedge aclk);
    end
    chk(what, 32'(RST_HOLD_CYC), 32'(lo));
  endtask

  task automatic quiet(input string what, input int n, input int pulses);
    int lo, pc;
    lo = 0;
    pc = 0;
    repeat (n)
    begin
      @(posedge aclk);
      if (core_rst_n !== 1'b1)
        lo++;
      if (pc_sp_clear === 1'b1)
        pc++;
    end
    chk(what, 32'h0, 32'(lo));
    chk("pc sp clear pulses", 32'(pulses), 32'(pc));
  endtask

  task automatic expire();
    wdt_expire <= 1'b1;
    @(posedge aclk);
    wdt_expire <= 1'b0;
  endtask

  task automatic t_por();
    logic [31:0] d;
    logic [1:0]  r;
    chk("core reset", 32'h1, 32'(core_rst_n));
    chk("por load", 32'h0, 32'(por_load));
    chk("wdt enable", 32'h1, 32'(wdt_enable));
    chk("lvr armed", 32'h1, 32'(lvr_armed));
    rdc("select", ADDR_LV_SELECT, 32'(LVS_POR));
    rdc("flags", ADDR_RST_FLAGS, 32'h0);
    rdc("wdt control", ADDR_WDT_CTRL, 32'(WDOG_CTRL_POR));
    rdc("status", ADDR_STATUS, 32'h0);
    axi_wr(8'h10, 8'hff, r);
    chk("unmapped write", {30'h0, RESP_SLVERR}, {30'h0, r});
    axi_rd(8'h10, d, r);
    chk("unmapped read", {30'h0, RESP_SLVERR}, {30'h0, r});
    chk("unmapped data", 32'h0, d);
  endtask

  task automatic t_wdt_code();
    wr(ADDR_WDT_CTRL, {WEC_DISABLE, 3'h7});
    repeat (2) @(posedge aclk);
    chk("wdt disabled", 32'h0, 32'(wdt_enable));
    wr(ADDR_WDT_CTRL, {WEC_ENABLE, 3'h7});
    repeat (2) @(posedge aclk);
    chk("wdt enabled", 32'h1, 32'(wdt_enable));
    wr(ADDR_WDT_CTRL, 8'h00);
    expect_rst("wdt code reset", 20);
    rdc("flags", ADDR_RST_FLAGS, 32'h1);
    rdc("wdt control", ADDR_WDT_CTRL, 32'(WDOG_CTRL_POR));
  endtask

  task automatic t_select();
    wr(ADDR_LV_SELECT, LVS_DISABLE);
    repeat (2) @(posedge aclk);
    chk("lvr disarmed", 32'h0, 32'(lvr_armed));
    low_supply <= 1'b1;
    quiet("disabled low supply", 40, 0);
    low_supply <= 1'b0;
    wr(ADDR_LV_SELECT, LVS_ENABLE_17V);
    // A write without byte 0 enabled must not plant a bad code
    wstrb <= 4'h0;
    wr(ADDR_LV_SELECT, 8'h33);
    wstrb <= 4'hf;
    quiet("masked write", 20, 0);
    wr(ADDR_LV_SELECT, 8'h33);
    expect_rst("select code reset", 20);
    rdc("flags", ADDR_RST_FLAGS, 32'h3);
    rdc("select", ADDR_LV_SELECT, 32'(LVS_POR));
    wr(ADDR_RST_FLAGS, 8'hfd);
    rdc("flags", ADDR_RST_FLAGS, 32'h1);
    wr(ADDR_RST_FLAGS, 8'hff);
    rdc("flags", ADDR_RST_FLAGS, 32'h1);
    wr(ADDR_RST_FLAGS, 8'h00);
    rdc("flags", ADDR_RST_FLAGS, 32'h0);
  endtask

  task automatic t_lv();
    expire();
    expect_rst("expiry reset", 4);
    rdc("status", ADDR_STATUS, 32'h1);
    low_supply <= 1'b1;
    repeat (3) @(posedge aclk);
    low_supply <= 1'b0;
    quiet("short low supply", 30, 0);
    low_supply <= 1'b1;
    expect_rst("low voltage reset", 40);
    low_supply <= 1'b0;
    rdc("flags", ADDR_RST_FLAGS, 32'h4);
    rdc("status", ADDR_STATUS, 32'h1);
    rdc("select", ADDR_LV_SELECT, 32'(LVS_ENABLE_17V));
  endtask

  task automatic t_halt();
    wr(ADDR_WDT_CTRL, {WEC_ENABLE, 3'h2});
    for (int m = 0; m < 2; m++)
    begin
      wr(ADDR_STATUS, 8'h00);
      sleep_mode <= (m == 0);
      idle_mode <= (m == 1);
      low_supply <= 1'b1;
      repeat (2) @(posedge aclk);
      chk("lvr armed halted", 32'h0, 32'(lvr_armed));
      expire();
      quiet("halted expiry", 40, 1);
      low_supply <= 1'b0;
      sleep_mode <= 1'b0;
      idle_mode <= 1'b0;
      rdc("status", ADDR_STATUS, 32'h3);
      rdc("wdt control", ADDR_WDT_CTRL, {24'h0, WEC_ENABLE, 3'h2});
      rdc("flags", ADDR_RST_FLAGS, 32'h4);
    end
    wr(ADDR_RST_FLAGS, 8'hfb);
    rdc("flags", ADDR_RST_FLAGS, 32'h0);
  endtask

  // Reset is held over several edges so that no assertion attempt straddles its release
  task automatic t_reset();
    wr(ADDR_LV_SELECT, LVS_DISABLE);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    chk("por load mid run", 32'h1, 32'(por_load));
    @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    chk("por load released", 32'h0, 32'(por_load));
    chk("core reset released", 32'h1, 32'(core_rst_n));
    chk("wdt enable released", 32'h1, 32'(wdt_enable));
    rdc("select", ADDR_LV_SELECT, 32'(LVS_POR));
    rdc("wdt control", ADDR_WDT_CTRL, 32'(WDOG_CTRL_POR));
    rdc("status", ADDR_STATUS, 32'h0);
  endtask

  initial
  begin
    aresetn = 1'b0;
    {awvalid, wvalid, arvalid, low_supply, sleep_mode, idle_mode, wdt_expire} = 7'h00;
    {bready, rready} = 2'h3;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hf;
    repeat (11) @(posedge aclk);
    chk("por load in reset", 32'h1, 32'(por_load));
    chk("core reset in reset", 32'h0, 32'(core_rst_n));
    @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_por();
    t_wdt_code();
    t_select();
    t_lv();
    t_halt();
    t_reset();
    summarize();
  end
endmodule // rsc_reset_ctrl_test
`default_nettype wire
